/* hdl/ccs_regs.vh */
// Overview of operation
// - Supply power-on reset holds registers at defaults for about 14 ms.
// - DSP may run as soon as PLL reports lock, no extra wait.
// - PLL lock takes about 2.4 to 3.5 ms; host waits before using it.
// - PLL reference input accepted anywhere from 8 MHz to 27 MHz.
// - Converters, PLL and DSP core each switch on and off under control.
// - Converter filters select 64x or 128x oversampling, 128x by default.
// - In PLL bypass the core clock comes straight from the master clock.
// - Bypass master clock may be 256, 512, 768 or 1024 times base rate.
// - Core clock stays stopped after reset until the enable bit is set.
// - Base rate follows input clock, further scaled to give 8 to 96 kHz.
`ifndef CCS_REGS_VH
`define CCS_REGS_VH

// ==========================================================
// Register map
`define CCS_ADDR_CLK_CTRL     16'h4000
`define CCS_ADDR_DSP_RATE     16'h40EB
`define CCS_CLK_CTRL_RESET    8'h00
`define CCS_DSP_RATE_RESET    8'h00
`define CCS_DSP_RATE_MASK     8'h0F
`define CCS_UNMAPPED_DATA     8'h00

// ==========================================================
// clock_control fields
`define CCS_BIT_CORE_EN       0
`define CCS_BIT_RATIO_LO      1
`define CCS_BIT_RATIO_HI      2
`define CCS_BIT_PLL_SRC       3
`define CCS_BIT_PLL_LOCK      7
`define CCS_CLK_CTRL_WMASK    8'h0F

// ==========================================================
// Timing
`define CCS_CLK_MHZ           200
`define CCS_POR_TIME_MS       14
`define CCS_POR_CYCLES        (`CCS_POR_TIME_MS * 1000 * `CCS_CLK_MHZ)
`define CCS_REF_WIN_US        1
`define CCS_REF_WIN_CYCLES    (`CCS_REF_WIN_US * `CCS_CLK_MHZ)
`define CCS_REF_MIN_MHZ       8
`define CCS_REF_MAX_MHZ       27
`define CCS_RATIO_UNIT        256
`define CCS_PLL_RATIO         1024

`endif

/* hdl/ccs_por_timer.v */
`include "ccs_regs.vh"

// ==========================================================
// Power-on hold timer
module ccs_por_timer #(
    parameter CYCLES = `CCS_POR_CYCLES,
    parameter WIDTH  = 22
) (
    input  wire clk,          // System clock
    input  wire rst_b,        // Async reset, active low
    input  wire supplyOk,     // Synchronised supply-good level
    output reg  porBusy       // High while reset is held
);
    localparam integer     LAST_INT = CYCLES - 1;
    localparam [WIDTH-1:0] LAST     = LAST_INT[WIDTH-1:0];

    reg [WIDTH-1:0] count_reg;

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count_reg <= {WIDTH{1'b0}};
            porBusy   <= 1'b1;
        end else if (!supplyOk) begin
            // Any supply dip restarts the full hold
            count_reg <= {WIDTH{1'b0}};
            porBusy   <= 1'b1;
        end else if (porBusy) begin
            if (count_reg == LAST) begin
                porBusy <= 1'b0;
            end else begin
                count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule // ccs_por_timer

/* hdl/ccs_clock_startup.v */
`include "ccs_regs.vh"

// ==========================================================
// Startup, power gating and core clock control
module ccs_clock_startup #(
    parameter POR_CYCLES = `CCS_POR_CYCLES,
    parameter POR_WIDTH  = 22,
    parameter FS_WIDTH   = 11
) (
    input  wire       clk,            // System clock, 200 MHz
    input  wire       rst_b,          // Async reset, active low
    input  wire       coreSupplyGood, // Core supply node monitor pin
    input  wire       mclkPin,        // Master clock pin
    input  wire       pllClkPin,      // PLL synthesised clock
    input  wire       pllLockPin,     // PLL lock indication
    input  wire [15:0] regAddr,       // Register address
    input  wire [7:0] regWrData,      // Register write data
    input  wire       regWrEn,        // Register write strobe
    input  wire       regRdEn,        // Register read strobe
    input  wire       adcPowerReq,    // ADC power request
    input  wire       dacPowerReq,    // DAC power request
    input  wire       pllPowerReq,    // PLL power request
    input  wire       dspPowerReq,    // DSP core power request
    input  wire       adcOsr64Req,    // ADC filter 64x when high
    input  wire       dacOsr64Req,    // DAC filter 64x when high
    input  wire [2:0] rateDivSel,     // Base rate divide minus one
    output reg  [7:0] regRdData,      // Register read data
    output reg        porActive,      // Internal reset held
    output reg        coreClkGate,    // Core clock gate enable
    output reg        coreClkSelPll,  // Core clock source is PLL
    output reg        coreClkOut,     // Gated core clock level
    output reg        adcPowerOn,     // ADC powered
    output reg        dacPowerOn,     // DAC powered
    output reg        pllPowerOn,     // PLL powered
    output reg        dspRun,         // DSP core running
    output reg        adcOsr64,       // ADC filter 64x
    output reg        dacOsr64,       // DAC filter 64x
    output reg  [3:0] dspRateField,   // DSP sample-rate field
    output reg        pllLocked,      // Synchronised lock status
    output reg        refInRange,     // Reference within 8..27 MHz
    output reg        fsTick          // One pulse per converter sample
);
    // ======================================================
    // Pin synchronisers
    reg supMeta_reg, supSync_reg;
    reg mclkMeta_reg, mclkSync_reg, mclkPrev_reg;
    reg pllcMeta_reg, pllcSync_reg, pllcPrev_reg;
    reg lockMeta_reg, lockSync_reg;

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            supMeta_reg  <= 1'b0;
            supSync_reg  <= 1'b0;
            mclkMeta_reg <= 1'b0;
            mclkSync_reg <= 1'b0;
            mclkPrev_reg <= 1'b0;
            pllcMeta_reg <= 1'b0;
            pllcSync_reg <= 1'b0;
            pllcPrev_reg <= 1'b0;
            lockMeta_reg <= 1'b0;
            lockSync_reg <= 1'b0;
        end else begin
            supMeta_reg  <= coreSupplyGood;
            supSync_reg  <= supMeta_reg;
            mclkMeta_reg <= mclkPin;
            mclkSync_reg <= mclkMeta_reg;
            mclkPrev_reg <= mclkSync_reg;
            pllcMeta_reg <= pllClkPin;
            pllcSync_reg <= pllcMeta_reg;
            pllcPrev_reg <= pllcSync_reg;
            lockMeta_reg <= pllLockPin;
            lockSync_reg <= lockMeta_reg;
        end
    end

    wire mclkRise = mclkSync_reg & ~mclkPrev_reg;
    wire pllRise  = pllcSync_reg & ~pllcPrev_reg;

    // ======================================================
    // Power-on reset
    wire porBusy;

    ccs_por_timer #(
        .CYCLES (POR_CYCLES),
        .WIDTH  (POR_WIDTH)
    ) u_por (
        .clk      (clk),
        .rst_b    (rst_b),
        .supplyOk (supSync_reg),
        .porBusy  (porBusy)
    );

    // ======================================================
    // Registers
    reg [7:0] clkCtrl_reg;
    reg [7:0] dspRate_reg;

    wire hitClk  = (regAddr == `CCS_ADDR_CLK_CTRL);
    wire hitDsp  = (regAddr == `CCS_ADDR_DSP_RATE);
    wire coreEn  = clkCtrl_reg[`CCS_BIT_CORE_EN];
    wire pllSrc  = clkCtrl_reg[`CCS_BIT_PLL_SRC];
    wire [1:0] ratio = clkCtrl_reg[`CCS_BIT_RATIO_HI:`CCS_BIT_RATIO_LO];

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            clkCtrl_reg <= `CCS_CLK_CTRL_RESET;
            dspRate_reg <= `CCS_DSP_RATE_RESET;
        end else if (porBusy) begin
            // Writes during the hold are lost
            clkCtrl_reg <= `CCS_CLK_CTRL_RESET;
            dspRate_reg <= `CCS_DSP_RATE_RESET;
        end else if (regWrEn) begin
            if (hitClk) begin
                // Ratio must match the real clock in bypass
                clkCtrl_reg <= regWrData & `CCS_CLK_CTRL_WMASK;
            end
            if (hitDsp) begin
                // Host lowers this for slow bypass clocks
                dspRate_reg <= regWrData & `CCS_DSP_RATE_MASK;
            end
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            regRdData <= 8'h00;
        end else if (regRdEn) begin
            if (hitClk) begin
                regRdData <= {pllLocked, 3'b000, clkCtrl_reg[3:0]};
            end else if (hitDsp) begin
                regRdData <= dspRate_reg;
            end else begin
                regRdData <= `CCS_UNMAPPED_DATA;
            end
        end
    end

    // ======================================================
    // Reference frequency check
    localparam integer WIN_INT  = `CCS_REF_WIN_CYCLES - 1;
    localparam integer MIN_INT  = `CCS_REF_MIN_MHZ * `CCS_REF_WIN_US;
    localparam integer MAX_INT  = `CCS_REF_MAX_MHZ * `CCS_REF_WIN_US;
    localparam [7:0]   WIN_LAST = WIN_INT[7:0];
    localparam [5:0]   REF_MIN  = MIN_INT[5:0];
    localparam [5:0]   REF_MAX  = MAX_INT[5:0];

    reg [7:0] win_reg;
    reg [5:0] edges_reg;

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            win_reg    <= 8'h00;
            edges_reg  <= 6'h00;
            refInRange <= 1'b0;
        end else if (win_reg == WIN_LAST) begin
            win_reg    <= 8'h00;
            edges_reg  <= 6'h00;
            refInRange <= (edges_reg >= REF_MIN) &&
                          (edges_reg <= REF_MAX);
        end else begin
            win_reg <= win_reg + 8'h01;
            if (mclkRise && edges_reg != 6'h3F) begin
                edges_reg <= edges_reg + 6'h01;
            end
        end
    end

    // ======================================================
    // Core clock, power and filter control
    wire srcReady = pllSrc ? (lockSync_reg & pllPowerReq) : 1'b1;
    wire gateNext = coreEn & srcReady & ~porBusy;
    wire srcLevel = pllSrc ? pllcSync_reg : mclkSync_reg;

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            porActive     <= 1'b1;
            coreClkGate   <= 1'b0;
            coreClkSelPll <= 1'b0;
            coreClkOut    <= 1'b0;
            adcPowerOn    <= 1'b0;
            dacPowerOn    <= 1'b0;
            pllPowerOn    <= 1'b0;
            dspRun        <= 1'b0;
            adcOsr64      <= 1'b0;
            dacOsr64      <= 1'b0;
            dspRateField  <= 4'h0;
            pllLocked     <= 1'b0;
        end else begin
            porActive     <= porBusy;
            // Gate also waits for lock as a safety net
            coreClkGate   <= gateNext;
            coreClkSelPll <= pllSrc;
            coreClkOut    <= gateNext & srcLevel;
            adcPowerOn    <= adcPowerReq & ~porBusy;
            dacPowerOn    <= dacPowerReq & ~porBusy;
            pllPowerOn    <= pllPowerReq & ~porBusy;
            // No wait beyond lock itself
            dspRun        <= dspPowerReq & gateNext;
            adcOsr64      <= adcOsr64Req & ~porBusy;
            dacOsr64      <= dacOsr64Req & ~porBusy;
            dspRateField  <= dspRate_reg[3:0];
            // Lock is only trusted while the PLL is powered
            pllLocked     <= lockSync_reg & pllPowerReq;
        end
    end

    // ======================================================
    // Base rate and converter sample tick
    localparam integer        UNIT_INT = `CCS_RATIO_UNIT;
    localparam integer        PLLR_INT = `CCS_PLL_RATIO;
    localparam [FS_WIDTH-1:0] UNIT     = UNIT_INT[FS_WIDTH-1:0];
    localparam [FS_WIDTH-1:0] PLLR     = PLLR_INT[FS_WIDTH-1:0];

    reg [FS_WIDTH-1:0] fsCnt_reg;
    reg [2:0]          scaleCnt_reg;
    reg [FS_WIDTH-1:0] fsLast;

    always @* begin
        if (pllSrc) begin
            fsLast = PLLR - {{(FS_WIDTH-1){1'b0}}, 1'b1};
        end else begin
            // 256, 512, 768 or 1024 source edges per base-rate period
            fsLast = UNIT * {{(FS_WIDTH-2){1'b0}}, ratio}
                     + UNIT - {{(FS_WIDTH-1){1'b0}}, 1'b1};
        end
    end

    wire srcRise = pllSrc ? pllRise : mclkRise;

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fsCnt_reg    <= {FS_WIDTH{1'b0}};
            scaleCnt_reg <= 3'h0;
            fsTick       <= 1'b0;
        end else if (!gateNext) begin
            // Counters restart cleanly when the clock returns
            fsCnt_reg    <= {FS_WIDTH{1'b0}};
            scaleCnt_reg <= 3'h0;
            fsTick       <= 1'b0;
        end else begin
            fsTick <= 1'b0;
            if (srcRise) begin
                if (fsCnt_reg >= fsLast) begin
                    fsCnt_reg <= {FS_WIDTH{1'b0}};
                    if (scaleCnt_reg >= rateDivSel) begin
                        scaleCnt_reg <= 3'h0;
                        fsTick       <= 1'b1;
                    end else begin
                        scaleCnt_reg <= scaleCnt_reg + 3'h1;
                    end
                end else begin
                    fsCnt_reg <= fsCnt_reg + {{(FS_WIDTH-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule // ccs_clock_startup

/* sim/ccs_clock_startup_checker.sv */
module ccs_clock_startup_checker (
    input wire logic        clk,           // System clock
    input wire logic        rst_b,         // Async reset, active low
    input wire logic [15:0] regAddr,       // Register address
    input wire logic [7:0]  regWrData,     // Write data
    input wire logic        regWrEn,       // Write strobe
    input wire logic        regRdEn,       // Read strobe
    input wire logic        adcPowerReq,   // ADC power request
    input wire logic [7:0]  regRdData,     // Read data
    input wire logic        porActive,     // Internal reset held
    input wire logic        coreClkGate,   // Core clock gate
    input wire logic        coreClkSelPll, // PLL source
    input wire logic        coreClkOut,    // Gated clock level
    input wire logic        adcPowerOn,    // ADC powered
    input wire logic        dspRun,        // DSP running
    input wire logic        pllLocked,     // Lock status
    input wire logic        fsTick         // Sample pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // ==========
    // Register port sequences
    sequence wrCoreBypass;
        regWrEn && !porActive && regAddr == 16'h4000
            && regWrData[0] && !regWrData[3];
    endsequence
    sequence rdUnmapped;
        regRdEn && regAddr != 16'h4000 && regAddr != 16'h40EB;
    endsequence

    // ==========
    // Properties
    chk_por_gate_off: assert property (
        porActive[*3] |-> !coreClkGate && !dspRun)
        else $error("core clock or DSP running during power-on hold");
    chk_core_en_gate: assert property (
        wrCoreBypass |-> ##2 coreClkGate)
        else $error("bypass core clock not enabled two cycles after write");
    // Gate and gated level are launched by the same edge
    chk_clk_out_gated: assert property (
        coreClkOut |-> coreClkGate)
        else $error("core clock toggles while gate is off");
    chk_pll_lock_gate: assert property (
        coreClkGate && coreClkSelPll |-> pllLocked || $past(pllLocked))
        else $error("PLL core clock gated on without lock");
    chk_dsp_needs_gate: assert property (
        dspRun |-> coreClkGate || $past(coreClkGate))
        else $error("DSP running without core clock");
    chk_adc_power_on: assert property (
        $rose(adcPowerReq) && !porActive |-> ##[1:2] adcPowerOn)
        else $error("ADC not powered after request");
    chk_tick_single: assert property (
        fsTick |=> !fsTick)
        else $error("sample pulse longer than one cycle");
    chk_unmapped_rd: assert property (
        rdUnmapped |=> regRdData == 8'h00)
        else $error("unmapped read returned nonzero data");
endmodule // ccs_clock_startup_checker

/* sim/ccs_host_model.sv */
module ccs_host_model #(
    parameter int LOCK_CYC = 100
) (
    input  wire logic       clk,            // Bench clock
    input  wire logic       supplyOn,       // Supply applied
    input  wire logic [7:0] mclkHalf,       // Master clock half period
    input  wire logic       pllOn,          // PLL powered
    output wire logic       coreSupplyGood, // Supply good level
    output logic            mclkPin,        // Master clock
    output logic            pllClkPin,      // PLL clock
    output logic            pllLockPin      // PLL lock
);
    timeunit 1ns;
    timeprecision 1ps;
    int         mCnt = 0;
    int         lCnt = 0;
    logic [1:0] ph   = 2'h0;

    assign coreSupplyGood = supplyOn;
    initial begin
        mclkPin = 1'h0;
        pllClkPin = 1'h0;
        pllLockPin = 1'h0;
    end
    always @(posedge clk) begin
        if (mCnt >= mclkHalf - 1) begin
            mCnt <= 0;
            mclkPin <= ~mclkPin;
        end else begin
            mCnt <= mCnt + 1;
        end
        ph <= ph + 2'h1;
        // Stopped PLL output rests low, never at its last level
        pllClkPin <= pllOn && ph[1];
        lCnt <= pllOn ? ((lCnt < LOCK_CYC) ? lCnt + 1 : lCnt) : 0;
        pllLockPin <= pllOn && lCnt >= LOCK_CYC;
    end
endmodule // ccs_host_model

/* sim/ccs_clock_startup_bench.sv */
module ccs_clock_startup_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'h0, rst_b = 1'h0, supplyOn = 1'h0;
    logic coreSupplyGood, mclkPin, pllClkPin, pllLockPin;
    logic [15:0] regAddr = 16'h0000;
    logic [7:0]  regWrData = 8'h00, mclkHalf = 8'h02, regRdData, mClk;
    logic regWrEn = 1'h0, regRdEn = 1'h0, adcPowerReq = 1'h0;
    logic dacPowerReq = 1'h0, pllPowerReq = 1'h0, dspPowerReq = 1'h0;
    logic adcOsr64Req = 1'h0, dacOsr64Req = 1'h0, mPor = 1'h1, mLock;
    logic [2:0]  rateDivSel = 3'h0;
    logic [3:0]  dspRateField;
    logic porActive, coreClkGate, coreClkSelPll, coreClkOut, adcPowerOn;
    logic dacPowerOn, pllPowerOn, dspRun, adcOsr64, dacOsr64, pllLocked;
    logic refInRange, fsTick;
    logic [31:0] r;
    int numErrors = 0, nChecks = 0, i, div;

    always #2.5 clk = ~clk;
    ccs_host_model hostU (.clk, .supplyOn, .mclkHalf, .pllOn(pllPowerReq),
        .coreSupplyGood, .mclkPin, .pllClkPin, .pllLockPin);
    ccs_clock_startup #(.POR_CYCLES(50)) dut_u (
        .clk, .rst_b, .coreSupplyGood, .mclkPin, .pllClkPin, .pllLockPin,
        .regAddr, .regWrData, .regWrEn, .regRdEn, .adcPowerReq, .dacPowerReq,
        .pllPowerReq, .dspPowerReq, .adcOsr64Req, .dacOsr64Req, .rateDivSel,
        .regRdData, .porActive, .coreClkGate, .coreClkSelPll, .coreClkOut,
        .adcPowerOn, .dacPowerOn, .pllPowerOn, .dspRun, .adcOsr64, .dacOsr64,
        .dspRateField, .pllLocked, .refInRange, .fsTick);

    // ==========
    // Compare, wait and bus tasks
    task automatic printVerdict;
        $display("checks %0d errors %0d", nChecks, numErrors);
        if (numErrors == 0 && nChecks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic cmpVal(string nm, logic [15:0] e, logic [15:0] g);
        nChecks++;
        if (g !== e) begin
            numErrors++;
            $display("CHECK FAILED %s exp %h seen %h", nm, e, g);
        end
    endtask
    function automatic logic sig(int k);
        sig = (k == 0) ? fsTick : (k == 1) ? porActive : pllLocked;
    endfunction
    task automatic waitFor(int k, logic v, int lim);
        for (int n = 0; n < lim && sig(k) !== v; n++) @(posedge clk);
        if (sig(k) !== v) begin
            numErrors++;
            printVerdict;
        end
    endtask
    task automatic gap(logic [15:0] e, string nm);
        int n;
        waitFor(0, 1'h1, 20000);
        @(posedge clk);
        for (n = 1; fsTick !== 1'h1 && n < 20000; n++) @(posedge clk);
        cmpVal(nm, e, n[15:0]);
    endtask
    task automatic wr(logic [15:0] a, logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'h1;
        @(posedge clk);
        regWrEn <= 1'h0;
        if (!mPor && a == 16'h4000) mClk = d & 8'h0F;
    endtask
    task automatic rdChk(logic [15:0] a, logic [7:0] e, string nm);
        @(posedge clk);
        regAddr <= a;
        regRdEn <= 1'h1;
        @(posedge clk);
        regRdEn <= 1'h0;
        @(posedge clk);
        cmpVal(nm, {8'h00, e}, {8'h00, regRdData});
    endtask

    // ==========
    // Main sequence
    initial begin
        void'($urandom(85385));
        mClk = 8'h00;
        mLock = 1'h0;
        repeat (6) @(posedge clk);
        rst_b <= 1'h1;
        supplyOn <= 1'h1;
        repeat (10) @(posedge clk);
        wr(16'h4000, 8'h01);
        repeat (30) @(posedge clk);
        cmpVal("porHeld", 16'h0001, {15'h0000, porActive});
        waitFor(1, 1'h0, 40);
        mPor = 1'h0;
        rdChk(16'h4000, 8'h00, "clkCtrlRst");
        rdChk(16'h40EB, 8'h00, "dspRst");
        rdChk(16'h4001, 8'h00, "unmapped");
        cmpVal("gateRst", 16'h0000, {15'h0000, coreClkGate});
        cmpVal("osrRst", 16'h0000, {14'h0000, dacOsr64, adcOsr64});
        for (i = 0; i < 6; i++) begin
            r = $urandom;
            adcPowerReq <= r[0];
            dacPowerReq <= r[1];
            pllPowerReq <= r[2];
            adcOsr64Req <= r[3];
            dacOsr64Req <= r[4];
            dspPowerReq <= r[5];
            repeat (3) @(posedge clk);
            cmpVal("power", {10'h000, 1'h0, r[4:0]}, {10'h000, dspRun,
                dacOsr64, adcOsr64, pllPowerOn, dacPowerOn, adcPowerOn});
        end
        pllPowerReq <= 1'h0;
        r = $urandom;
        wr(16'h40EB, r[7:0]);
        rdChk(16'h40EB, r[7:0] & 8'h0F, "dspRate");
        cmpVal("dspField", {12'h000, r[3:0]}, {12'h000, dspRateField});
        div = $urandom_range(1, 0);
        rateDivSel <= div[2:0];
        for (i = 0; i < 4; i++) begin
            wr(16'h4000, 8'(i * 2 + 1));
            rdChk(16'h4000, mClk, "clkCtrl");
            gap(16'(4 * 256 * (i + 1) * (div + 1)), "bypassGap");
        end
        cmpVal("selPll", 16'h0000, {15'h0000, coreClkSelPll});
        // Too fast, too slow, then inside the accepted band
        for (i = 0; i < 3; i++) begin
            mclkHalf <= (i == 0) ? 8'h02 : (i == 1) ? 8'h14 : 8'h04;
            repeat (600) @(posedge clk);
            cmpVal("refRange", 16'(i == 2), {15'h0000, refInRange});
        end
        wr(16'h4000, 8'h09);
        repeat (10) @(posedge clk);
        cmpVal("gateNoLock", 16'h0000, {15'h0000, coreClkGate});
        pllPowerReq <= 1'h1;
        dspPowerReq <= 1'h1;
        rdChk(16'h4000, 8'h09, "notLocked");
        waitFor(2, 1'h1, 200);
        mLock = 1'h1;
        rdChk(16'h4000, {mLock, 3'h0, mClk[3:0]}, "locked");
        cmpVal("dspPll", 16'h0007,
            {13'h0000, coreClkSelPll, coreClkGate, dspRun});
        gap(16'(4 * 1024 * (div + 1)), "pllGap");
        pllPowerReq <= 1'h0;
        supplyOn <= 1'h0;
        mPor = 1'h1;
        repeat (5) @(posedge clk);
        cmpVal("porAgain", 16'h0001, {15'h0000, porActive});
        supplyOn <= 1'h1;
        waitFor(1, 1'h0, 100);
        rdChk(16'h4000, 8'h00, "clkCtrlReload");
        printVerdict;
    end
endmodule // ccs_clock_startup_bench

bind ccs_clock_startup ccs_clock_startup_checker chkU (
    .clk, .rst_b, .regAddr, .regWrData, .regWrEn, .regRdEn, .adcPowerReq,
    .regRdData, .porActive, .coreClkGate, .coreClkSelPll, .coreClkOut,
    .adcPowerOn, .dspRun, .pllLocked, .fsTick);
